// ### rtl/op_mode_pkg.sv
// Constants and types for the operating-mode status and control registers
package op_mode_pkg;

   // Register byte addresses as seen on the register port
   localparam logic [31:0] STATUS_ADDR      = 32'hffff1020;
   localparam logic [31:0] CONTROL_ADDR     = 32'hffff102a;
   // Aligned words that hold the two registers (big-endian lanes)
   localparam logic [31:0] STATUS_WORD      = 32'hffff1020;
   localparam logic [31:0] CONTROL_WORD     = 32'hffff1028;
   // Byte that carries the writable ROM speed bit
   localparam logic [31:0] CONTROL_LOW_BYTE = 32'hffff102b;

   // Control register layout and reset value
   localparam logic [15:0] CONTROL_RESET    = 16'h001c;
   localparam logic [15:0] CONTROL_ONES     = 16'h000c;
   localparam int          ROM_SPEED_BIT    = 4;
   localparam logic        ROM_SPEED_RESET  = 1'h1;

   // Status register layout
   localparam int          STRAP_COUNT      = 6;
   localparam int          OP_STRAP_LSB     = 0;
   localparam int          CLK_STRAP_LSB    = 3;
   localparam logic [9:0]  STATUS_RESERVED  = 10'h000;

   // Access sizes on the register port
   localparam logic [1:0]  SIZE_BYTE        = 2'h0;
   localparam logic [1:0]  SIZE_HALF        = 2'h1;
   localparam logic [1:0]  SIZE_WORD        = 2'h2;

   // Strap settling wait after reset release
   localparam int          CLOCK_PERIOD_PS  = 8000;
   localparam int          STRAP_SETTLE_NS  = 24;
   localparam int          SETTLE_CYCLES    =
      (STRAP_SETTLE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   typedef enum logic [1:0] {
      ST_SETTLE  = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_HOLD    = 2'b10
   } capture_state_e;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [1:0]  size;
      logic        wr;
      logic        rd;
   } reg_req_s;

   typedef struct packed {
      logic [2:0] op_mode;
      logic [2:0] clk_mode;
      logic       valid;
   } mode_out_s;

endpackage

// ### rtl/op_mode_status_control.sv
// Operating-mode strap capture, mode status and ROM access control
//
// What this block does
// (RL1) Lower three straps give chip operating mode
// (RL2) Upper three straps give clock operating mode
// (RL3) Flash write enable input gates flash programming
// (RL4) Mode status: 16-bit, read-only
// (RL5) Status bits 15..6 undefined; read as zero
// (RL6) Status bits 5..0 are straps latched at reset
// (RL7) Byte, half and word accesses all accepted
// (RL8) Control register 16-bit read/write, ROM access mode
// (RL9) Power-on reset loads control with 001c
// (RL10) Standby leaves control register untouched
// (RL11) Bit 4: 0 fast ROM, 1 slow ROM
// (RL12) Software should normally choose fast ROM
// (RL13) Control bits 15..5 read zero
// (RL14) Control bits 3..2 read one
// (RL15) Control bits 1..0 read zero
// (RL16) Board holds straps steady while powered
// (RL17) Writes to read-only bits are ignored
`timescale 1ns/1ps
`default_nettype none

module op_mode_status_control (
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   input  wire op_mode_pkg::reg_req_s i_req,
   output var  logic [31:0]           o_rdata,
   input  wire logic [5:0]            i_mode_strap,
   input  wire logic                  i_flash_write_enable,
   input  wire logic                  i_standby,
   output var  op_mode_pkg::mode_out_s o_mode,
   output var  logic                  o_flash_write_allow,
   output var  logic                  o_rom_speed_select
);

   // Big-endian lane image of one aligned word
   function automatic logic [31:0] word_image(
      input logic [31:0] word_addr,
      input logic [15:0] status_val,
      input logic [15:0] control_val
   );
      logic [31:0] img;
      img = 32'h0000_0000;
      if (word_addr == op_mode_pkg::STATUS_WORD) begin
         img = {status_val, 16'h0000};
      end else if (word_addr == op_mode_pkg::CONTROL_WORD) begin
         img = {16'h0000, control_val};
      end
      return img;
   endfunction

   // True when an access of this size may start at this address
   function automatic logic aligned(
      input logic [31:0] addr,
      input logic [1:0]  size
   );
      logic ok;
      ok = 1'b0;
      case (size)
         op_mode_pkg::SIZE_BYTE: ok = 1'b1;
         op_mode_pkg::SIZE_HALF: ok = (addr[0] == 1'b0);
         op_mode_pkg::SIZE_WORD: ok = (addr[1:0] == 2'h0);
         default:                ok = 1'b0;
      endcase
      return ok;
   endfunction

   // True when the access touches the given byte address
   function automatic logic covers(
      input logic [31:0] addr,
      input logic [1:0]  size,
      input logic [31:0] target
   );
      logic hit;
      hit = 1'b0;
      if (aligned(addr, size)) begin
         case (size)
            op_mode_pkg::SIZE_BYTE: hit = (addr == target);
            op_mode_pkg::SIZE_HALF: hit = (addr[31:1] == target[31:1]);
            op_mode_pkg::SIZE_WORD: hit = (addr[31:2] == target[31:2]);
            default:                hit = 1'b0;
         endcase
      end
      return hit;
   endfunction

   // Strap synchroniser stages; stage one feeds only stage two
   logic [5:0]                   strap_s1;
   logic [5:0]                   strap_s2;
   logic [5:0]                   strap_s3;
   logic [5:0]                   strap_agree;
   logic [5:0]                   strap_latch;
   logic                         fwe_s1;
   logic                         fwe_s2;
   logic                         fwe_s3;
   logic                         fwe_level;
   op_mode_pkg::capture_state_e  state;
   op_mode_pkg::capture_state_e  next_state;
   logic [3:0]                   settle_count;
   logic                         rom_speed;
   logic [15:0]                  status_val;
   logic [15:0]                  control_val;
   logic                         ctrl_write;
   logic [31:0]                  img;
   logic [31:0]                  next_rdata;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         strap_s1 <= 6'h00;
         strap_s2 <= 6'h00;
         strap_s3 <= 6'h00;
         fwe_s1   <= 1'b0;
         fwe_s2   <= 1'b0;
         fwe_s3   <= 1'b0;
      end else begin
         strap_s1 <= i_mode_strap;
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
         fwe_s1   <= i_flash_write_enable;
         fwe_s2   <= fwe_s1;
         fwe_s3   <= fwe_s2;
      end
   end

   // Per-bit agreement of the last two stages
   genvar gi;
   generate
      for (gi = 0; gi < op_mode_pkg::STRAP_COUNT; gi = gi + 1) begin : g_agree
         assign strap_agree[gi] = ~(strap_s2[gi] ^ strap_s3[gi]);
      end
   endgenerate

   // Flash enable counts only once two stages agree; glitches held off
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         fwe_level <= 1'b0;
      end else if (fwe_s2 == fwe_s3) begin
         fwe_level <= fwe_s3; // RL3
      end
   end

   // Capture sequence: wait for the pipe to fill, then latch once
   always_comb begin
      next_state = state;
      case (state)
         op_mode_pkg::ST_SETTLE: begin
            if (settle_count ==
                4'(op_mode_pkg::SETTLE_CYCLES - 1)) begin
               next_state = op_mode_pkg::ST_CAPTURE;
            end
         end
         op_mode_pkg::ST_CAPTURE: begin
            if (&strap_agree) begin
               next_state = op_mode_pkg::ST_HOLD;
            end
         end
         op_mode_pkg::ST_HOLD: next_state = op_mode_pkg::ST_HOLD;
         default:              next_state = op_mode_pkg::ST_SETTLE;
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state <= op_mode_pkg::ST_SETTLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         settle_count <= 4'h0;
      end else if (state == op_mode_pkg::ST_SETTLE) begin
         settle_count <= settle_count + 4'h1;
      end
   end

   // Straps frozen after capture; later pin changes are not seen
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         strap_latch <= 6'h00;
      end else if (state == op_mode_pkg::ST_CAPTURE && (&strap_agree)) begin
         strap_latch <= strap_s3; // RL6
      end
   end

   // ROM speed bit; only a power-on reset restores it, not standby
   assign ctrl_write = i_req.wr &&
      covers(i_req.addr, i_req.size, op_mode_pkg::CONTROL_LOW_BYTE);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rom_speed <= op_mode_pkg::ROM_SPEED_RESET; // RL9
      end else if (ctrl_write) begin
         // Same bit position for byte, half and word writes
         rom_speed <= i_req.wdata[op_mode_pkg::ROM_SPEED_BIT]; // RL11 RL10
      end
   end

   // Register images; fixed bits never stored, so writes cannot move them
   always_comb begin
      status_val = {op_mode_pkg::STATUS_RESERVED, strap_latch}; // RL4 RL5
      control_val = op_mode_pkg::CONTROL_ONES; // RL13 RL14 RL15 RL17
      control_val[op_mode_pkg::ROM_SPEED_BIT] = rom_speed; // RL8
   end

   // Read path: pick lanes, right-justify; misaligned reads return zero
   always_comb begin
      img = word_image({i_req.addr[31:2], 2'h0}, status_val, control_val);
      next_rdata = 32'h0000_0000;
      if (i_req.rd && aligned(i_req.addr, i_req.size)) begin
         case (i_req.size)
            op_mode_pkg::SIZE_BYTE: begin
               case (i_req.addr[1:0])
                  2'h0:    next_rdata = {24'h000000, img[31:24]}; // RL7
                  2'h1:    next_rdata = {24'h000000, img[23:16]};
                  2'h2:    next_rdata = {24'h000000, img[15:8]};
                  default: next_rdata = {24'h000000, img[7:0]};
               endcase
            end
            op_mode_pkg::SIZE_HALF: begin
               if (i_req.addr[1]) begin
                  next_rdata = {16'h0000, img[15:0]};
               end else begin
                  next_rdata = {16'h0000, img[31:16]};
               end
            end
            op_mode_pkg::SIZE_WORD: next_rdata = img;
            default:                next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else begin
         o_rdata <= next_rdata;
      end
   end

   // Mode outputs registered from the latched straps
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_mode              <= '0;
         o_flash_write_allow <= 1'b0;
         o_rom_speed_select  <= op_mode_pkg::ROM_SPEED_RESET;
      end else begin
         o_mode.op_mode  <=
            strap_latch[op_mode_pkg::OP_STRAP_LSB +: 3]; // RL1
         o_mode.clk_mode <=
            strap_latch[op_mode_pkg::CLK_STRAP_LSB +: 3]; // RL2
         o_mode.valid    <= (state == op_mode_pkg::ST_HOLD);
         o_flash_write_allow <= fwe_level; // RL3
         // Advice only: slow mode stays legal if software keeps it
         o_rom_speed_select  <= rom_speed; // RL11
      end
   end

   // Checks on the block's outputs and internal state
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   property p_op_mode;
      o_mode.valid |-> o_mode.op_mode == $past(status_val[2:0]);
   endproperty
   a_op_mode: assert property (p_op_mode) // RL1
      else $error("op mode output differs from latched straps");

   property p_clk_mode;
      o_mode.valid |-> o_mode.clk_mode == $past(status_val[5:3]);
   endproperty
   a_clk_mode: assert property (p_clk_mode) // RL2
      else $error("clock mode output differs from latched straps");

   property p_flash_gate;
      (!fwe_s2 && !fwe_s3) |=> ##1 !o_flash_write_allow;
   endproperty
   a_flash_gate: assert property (p_flash_gate) // RL3
      else $error("flash write allowed with enable input low");

   property p_status_read;
      (i_req.rd && i_req.size == op_mode_pkg::SIZE_HALF &&
       i_req.addr == op_mode_pkg::STATUS_ADDR)
      |=> o_rdata == {16'h0000, 10'h000, $past(strap_latch)};
   endproperty
   a_status_read: assert property (p_status_read) // RL4 RL5 RL6
      else $error("status half read returned wrong value");

   property p_status_frozen;
      (state == op_mode_pkg::ST_HOLD) |=> $stable(strap_latch)[*4];
   endproperty
   a_status_frozen: assert property (p_status_frozen) // RL6
      else $error("latched straps moved after capture");

   property p_byte_read;
      (i_req.rd && i_req.size == op_mode_pkg::SIZE_BYTE &&
       i_req.addr == op_mode_pkg::CONTROL_LOW_BYTE)
      |=> o_rdata == {24'h000000, 3'h0, $past(rom_speed), 4'hc};
   endproperty
   a_byte_read: assert property (p_byte_read) // RL7 RL13 RL14 RL15
      else $error("control byte read returned wrong value");

   property p_word_read;
      (i_req.rd && i_req.size == op_mode_pkg::SIZE_WORD &&
       i_req.addr == op_mode_pkg::CONTROL_WORD)
      |=> o_rdata[15:0] == {11'h000, $past(rom_speed), 4'hc};
   endproperty
   a_word_read: assert property (p_word_read) // RL8 RL7
      else $error("control word read returned wrong value");

   property p_reset_value;
      $past(i_rst) |-> rom_speed == 1'b1;
   endproperty
   a_reset_value: assert property (@(posedge i_clock) p_reset_value) // RL9
      else $error("control not at reset value after reset");

   property p_standby_keep;
      (i_standby && !ctrl_write) |=> $stable(rom_speed);
   endproperty
   a_standby_keep: assert property (p_standby_keep) // RL10
      else $error("control changed in standby without a write");

   // Bit lands one edge after the strobe, the output one edge later
   property p_rom_write;
      ctrl_write |=> ##1 o_rom_speed_select ==
         $past(i_req.wdata[op_mode_pkg::ROM_SPEED_BIT], 2);
   endproperty
   a_rom_write: assert property (p_rom_write) // RL11
      else $error("ROM speed output did not follow the write");

   property p_ro_write;
      (i_req.wr && !ctrl_write) |=> $stable(rom_speed) &&
         $stable(strap_latch);
   endproperty
   a_ro_write: assert property (p_ro_write) // RL17
      else $error("write to read-only bits changed state");

   c_capture: cover property (state == op_mode_pkg::ST_CAPTURE ##1
      state == op_mode_pkg::ST_HOLD);
   c_fast_rom: cover property (ctrl_write &&
      !i_req.wdata[op_mode_pkg::ROM_SPEED_BIT]);
   c_word_status: cover property (i_req.rd &&
      i_req.size == op_mode_pkg::SIZE_WORD &&
      i_req.addr == op_mode_pkg::STATUS_WORD);
   c_standby: cover property (i_standby && ctrl_write);

endmodule // op_mode_status_control

`default_nettype wire

// ### verification/strap_board_model.sv
// Board model: mode strap resistors and flash write enable jumper
`timescale 1ns/1ps
`default_nettype none

module strap_board_model #(
   parameter logic [5:0] STRAP_LEVELS = 6'h00
) (
   input  wire logic       i_flash_jumper,
   output var  logic [5:0] o_mode_strap,
   output var  logic       o_flash_write_enable
);
   // Straps are resistors, so they never move while powered
   assign o_mode_strap = STRAP_LEVELS;
   // Jumper level goes straight to the interlock pin
   assign o_flash_write_enable = i_flash_jumper;
endmodule // strap_board_model
`default_nettype wire

// ### verification/op_mode_status_control_tb.sv
// Self-checking bench for mode status and ROM access control
`timescale 1ns/1ps
`default_nettype none

module op_mode_status_control_tb;
   // Fields differ and are not palindromes, so swaps and flips show
   localparam logic [5:0]   STRAPS = 6'h19;
   logic                    clock = 1'b0;
   logic                    rst = 1'b1;
   logic                    standby = 1'b0;
   logic                    fwe_level = 1'b0;
   op_mode_pkg::reg_req_s   req = '0;
   logic [31:0]             rdata;
   logic [5:0]              strap;
   logic                    flash_write_enable;
   op_mode_pkg::mode_out_s  mode;
   logic                    flash_allow;
   logic                    rom_slow;
   int                      bad_count = 0;
   int                      checked = 0;

   // 125 MHz clock
   always #4 clock = ~clock;

   strap_board_model #(.STRAP_LEVELS(STRAPS)) u_strap_board_model (
      .i_flash_jumper      (fwe_level),
      .o_mode_strap        (strap),
      .o_flash_write_enable(flash_write_enable)
   );

   op_mode_status_control u_op_mode_status_control (
      .i_clock             (clock),
      .i_rst               (rst),
      .i_req               (req),
      .o_rdata             (rdata),
      .i_mode_strap        (strap),
      .i_flash_write_enable(flash_write_enable),
      .i_standby           (standby),
      .o_mode              (mode),
      .o_flash_write_allow (flash_allow),
      .o_rom_speed_select  (rom_slow)
   );

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe, then idle
   task automatic reg_write(input logic [31:0] addr, input logic [1:0] size,
                            input logic [31:0] data);
      @(posedge clock);
      req <= '{addr: addr, wdata: data, size: size, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      req <= '0;
   endtask

   // Read data stands only in the cycle after the strobe is taken
   task automatic reg_read(input logic [31:0] addr, input logic [1:0] size,
                           input logic [31:0] exp);
      @(posedge clock);
      req <= '{addr: addr, wdata: 32'h0, size: size, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      req <= '0;
      #1;
      check(rdata, exp);
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      repeat (12) @(posedge clock);
      check(rom_slow, 1'b1);
      rst <= 1'b0;
   endtask

   // Bounded wait for strap capture
   task automatic wait_capture;
      int n;
      n = 0;
      while (mode.valid !== 1'b1 && n < 50) begin
         @(posedge clock);
         #1;
         n++;
      end
      check(mode.valid, 1'b1);
   endtask

   task automatic test_reset_values;
      reg_read(op_mode_pkg::CONTROL_ADDR, op_mode_pkg::SIZE_HALF,
               32'h1c);
      check(rom_slow, 1'b1);
      reg_read(32'hffff102a, op_mode_pkg::SIZE_BYTE, 32'h00);
      reg_read(32'hffff102b, op_mode_pkg::SIZE_BYTE, 32'h1c);
   endtask

   task automatic test_status;
      wait_capture();
      check(mode.op_mode, STRAPS[2:0]);
      check(mode.clk_mode, STRAPS[5:3]);
      reg_read(op_mode_pkg::STATUS_ADDR, op_mode_pkg::SIZE_HALF,
               {26'h0, STRAPS});
      reg_read(32'hffff1020, op_mode_pkg::SIZE_BYTE, 32'h00);
      reg_read(32'hffff1021, op_mode_pkg::SIZE_BYTE, {26'h0, STRAPS});
      reg_read(op_mode_pkg::STATUS_WORD, op_mode_pkg::SIZE_WORD,
               {10'h0, STRAPS, 16'h0});
      // Writing the status register must not disturb it
      reg_write(op_mode_pkg::STATUS_ADDR, op_mode_pkg::SIZE_HALF, 32'hffff);
      reg_read(op_mode_pkg::STATUS_ADDR, op_mode_pkg::SIZE_HALF,
               {26'h0, STRAPS});
      reg_read(32'hffff1030, op_mode_pkg::SIZE_WORD, 32'h0);
   endtask

   task automatic test_control;
      // Software picks fast ROM, as it normally should
      reg_write(op_mode_pkg::CONTROL_LOW_BYTE, op_mode_pkg::SIZE_BYTE,
                32'h0);
      reg_read(op_mode_pkg::CONTROL_ADDR, op_mode_pkg::SIZE_HALF,
               32'h0c);
      check(rom_slow, 1'b0);
      // All ones: only the speed bit may take
      reg_write(op_mode_pkg::CONTROL_WORD, op_mode_pkg::SIZE_WORD,
                32'hffffffff);
      reg_read(op_mode_pkg::CONTROL_WORD, op_mode_pkg::SIZE_WORD,
               32'h1c);
      check(rom_slow, 1'b1);
      reg_write(op_mode_pkg::CONTROL_ADDR, op_mode_pkg::SIZE_HALF, 32'h0);
      reg_read(op_mode_pkg::CONTROL_ADDR, op_mode_pkg::SIZE_HALF,
               32'h0c);
      reg_write(32'hffff102a, op_mode_pkg::SIZE_BYTE, 32'hff);
      reg_read(op_mode_pkg::CONTROL_WORD, op_mode_pkg::SIZE_WORD,
               32'h0c);
   endtask

   task automatic test_standby;
      @(posedge clock);
      standby <= 1'b1;
      repeat (20) @(posedge clock);
      reg_read(op_mode_pkg::CONTROL_ADDR, op_mode_pkg::SIZE_HALF,
               32'h0c);
      // Drop standby on an edge, then power-on reset in mid-run
      @(posedge clock);
      standby <= 1'b0;
      do_reset();
      reg_read(op_mode_pkg::CONTROL_ADDR, op_mode_pkg::SIZE_HALF,
               32'h1c);
      wait_capture();
      reg_read(op_mode_pkg::STATUS_ADDR, op_mode_pkg::SIZE_HALF,
               {26'h0, STRAPS});
   endtask

   // Interlock follows the pin a few cycles late; 8 is ample
   task automatic test_flash;
      @(posedge clock);
      fwe_level <= 1'b1;
      repeat (8) @(posedge clock);
      #1;
      check(flash_allow, 1'b1);
      @(posedge clock);
      fwe_level <= 1'b0;
      repeat (8) @(posedge clock);
      #1;
      check(flash_allow, 1'b0);
   endtask

   // Main sequence
   initial begin
      do_reset();
      test_reset_values();
      test_status();
      test_control();
      test_flash();
      test_standby();
      stop_test();
   end

   // Watchdog: whole run needs well under 1000 cycles
   initial begin
      #100000;
      bad_count++;
      stop_test();
   end
endmodule // op_mode_status_control_tb
`default_nettype wire
